// [fcl_regs.vh]
`ifndef FCL_REGS_VH
`define FCL_REGS_VH
// register word addresses (port address, 5 bits)
`define FCL_ADDR_CLKDIV     5'h00
`define FCL_ADDR_OBJ_IDX    5'h01
`define FCL_ADDR_ECC_IDX    5'h02
`define FCL_ADDR_STATUS     5'h03
`define FCL_ADDR_OBJ_DATA   5'h04
`define FCL_ADDR_ECC_DATA   5'h05
`define FCL_ADDR_OPTION     5'h06
`define FCL_ADDR_ECC_FLAGS  5'h07
`define FCL_ADDR_RSV0       5'h08
`define FCL_ADDR_RSV1       5'h09
`define FCL_ADDR_RSV2       5'h0a
`define FCL_ADDR_RSV3       5'h0b
`define FCL_ADDR_RSV4       5'h0c
// clock divider register fields
`define FCL_DIV_LOADED_BIT  7
`define FCL_DIV_RESET       7'h00
// status register fields
`define FCL_STAT_COMMAND_COMPLETE_FLAG_BIT   7
`define FCL_STAT_ACCESS_ERROR_FLAG_BIT 5
`define FCL_STAT_PVIOL_BIT  4
// ecc flags register fields
`define FCL_ECC_SINGLE_BIT  0
`define FCL_ECC_DOUBLE_BIT  1
// option byte location in program flash
`define FCL_OPT_ADDR        23'h7f_ff0e
`define FCL_OPT_ERASED      8'hff
// timing
`define FCL_TIMEBASE_HZ     1000000
`define FCL_CLK_HZ          100000000
`endif

// [fcl_top.v]
`timescale 1ns/1ps
// Behaviour
// - five reserved test registers read zero
// - captured fault held until its flag clears
// - double-bit fault wins over single-bit
// - index 000: check bits, zero, upper address
// - index 001: lower 16 address bits
// - indices 010-101 data words, data-flash 010
// - ecc indices 110,111 read zero
// - check byte 8 bits, or 6 with 00
// - load option byte from flash at reset
// - double fault on option read sets all ones
// - option register read-only
// - divider write while idle sets divider-loaded flag
// - no divider: program/erase command refused, access error
// - busy: ignore command object writes
// - writing one to complete flag launches
// - flag zero until done; results returned
// - object index selects command object word
// - word 000 high byte is command code
// - object indices 110,111 ignored, read zero
`include "fcl_regs.vh"
module fcl_top #(
  parameter       ADDR_W = 5,     // register address width
  parameter [7:0] PGM_CMD_LO = 8'h06, // first program/erase code
  parameter [7:0] PGM_CMD_HI = 8'h12  // last program/erase code
) (
  input  wire        core_clk_i,     // bus clock
  input  wire        reset_n_i,      // sync reset, active low
  input  wire [4:0]  reg_addr_i,     // register address
  input  wire [15:0] reg_wdata_i,    // write data
  input  wire        reg_wr_i,       // write strobe
  input  wire        reg_rd_i,       // read strobe
  output reg  [15:0] reg_rdata_o,    // read data, one cycle later
  // option byte fetch from the flash array after reset
  output reg         opt_rd_o,       // request option phrase read
  output reg  [22:0] opt_addr_o,     // global address of option byte
  input  wire        opt_valid_i,    // phrase read finished
  input  wire [7:0]  opt_data_i,     // option byte
  input  wire        opt_dbl_i,      // double fault on that read
  // ecc fault reports from the read path (same clock)
  input  wire        ecc_single_i,   // single-bit fault pulse
  input  wire        ecc_double_i,   // double-bit fault pulse
  input  wire        ecc_dflash_i,   // fault is in data flash
  input  wire [7:0]  ecc_check_i,    // check bits as read
  input  wire [22:0] ecc_addr_i,     // faulting global address
  input  wire [63:0] ecc_data_i,     // uncorrected phrase
  // command engine
  output reg         cmd_start_o,    // one-cycle launch pulse
  output reg  [95:0] cmd_params_o,   // six words, word 0 first
  input  wire        cmd_done_i,     // engine finished pulse
  input  wire        cmd_pviol_i,    // engine protection violation
  input  wire        cmd_res_we_i,   // write a result word
  input  wire [2:0]  cmd_res_idx_i,  // result word index
  input  wire [15:0] cmd_res_data_i, // result word
  output reg         timebase_tick_o // 1 MHz program time base
);

  // fsm for the option load after reset
  localparam [1:0] OPT_REQ  = 2'd0;  // issue read
  localparam [1:0] OPT_WAIT = 2'd1;  // wait for flash
  localparam [1:0] OPT_DONE = 2'd2;  // normal operation

  reg  [1:0]  opt_state_r;           // option load state
  reg  [7:0]  option_r;              // option byte
  reg  [6:0]  div_value_r;           // clock divide value
  reg         div_loaded_r;          // divider-loaded flag
  reg  [6:0]  tb_cnt_r;              // time base counter
  reg  [2:0]  obj_idx_r;             // command object index
  reg  [2:0]  ecc_idx_r;             // ecc result index
  reg         command_complete_flag_r;                // command complete flag
  reg         access_error_flag_r;              // access error flag
  reg         pviol_r;               // protection violation flag
  reg  [15:0] obj_mem_r [0:5];       // command object array
  reg         ecc_sgl_r;             // single fault flag
  reg         ecc_dbl_r;             // double fault flag
  reg         ecc_df_r;              // captured fault in data flash
  reg  [7:0]  ecc_chk_r;             // captured check bits
  reg  [22:0] ecc_addr_r;            // captured address
  reg  [63:0] ecc_data_r;            // captured phrase
  reg  [15:0] rd_nxt;                // read mux
  wire        wr_clkdiv;             // decoded writes
  wire        wr_status;
  wire        wr_obj;
  wire        wr_eflags;
  wire        wr_obj_idx;            // object index write hit
  wire        wr_ecc_idx;            // ecc index write hit
  wire        launch;
  wire        is_pgm;
  wire        ecc_any;
  wire [7:0]  cmd_code;
  integer     i;

  // one decoded write hit; shared by every register software can write,
  // so that all of them agree on strobe and address qualification
  function wr_hit;
    input              wr;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] target;
    begin
      wr_hit = wr && (a == target);
    end
  endfunction

  // word select into the 64-bit phrase, word 0 is the top word
  function [15:0] phrase_word;
    input [63:0] ph;
    input [1:0]  w;
    begin
      phrase_word = ph[63 - w*16 -: 16];
    end
  endfunction

  // write decode; reads need no decode here, the read mux does it
  // the bus never waits, so every hit not refused while busy is acted on in its own cycle
  assign wr_clkdiv  = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_CLKDIV);
  assign wr_status  = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_STATUS);
  assign wr_obj     = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_OBJ_DATA);
  assign wr_eflags  = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_ECC_FLAGS);
  assign wr_obj_idx = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_OBJ_IDX);
  assign wr_ecc_idx = wr_hit(reg_wr_i, reg_addr_i, `FCL_ADDR_ECC_IDX);
  // the option, reserved and unmapped addresses get no write hit at
  // all: their contents cannot be disturbed by any software write
  assign cmd_code  = obj_mem_r[0][15:8];
  // program and erase codes need a loaded divider
  assign is_pgm    = (cmd_code >= PGM_CMD_LO) && (cmd_code <= PGM_CMD_HI);
  // launch only when idle and errors clear
  assign launch    = wr_status && reg_wdata_i[`FCL_STAT_COMMAND_COMPLETE_FLAG_BIT] &&
                     command_complete_flag_r && !access_error_flag_r && !pviol_r &&
                     opt_state_r == OPT_DONE;
  assign ecc_any   = ecc_single_i || ecc_double_i;

  // option byte fetch: reads the configuration byte once after reset
  // the request is a level held until the flash answers; the flash
  // read path owns the timing, so no timeout is kept here
  // launches wait for this fetch, so a command never runs with a
  // stale or half-loaded option byte
  // limitation: a flash that never answers leaves the block unable to
  // launch; that is preferred over running with unknown options
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      opt_state_r <= OPT_REQ;
      option_r    <= 8'h00;
      opt_rd_o    <= 1'b0;
      opt_addr_o  <= 23'h00_0000;
    end else begin
      case (opt_state_r)
        OPT_REQ: begin
          opt_rd_o    <= 1'b1;
          opt_addr_o  <= `FCL_OPT_ADDR;
          opt_state_r <= OPT_WAIT;
        end
        OPT_WAIT: begin
          if (opt_valid_i) begin
            opt_rd_o    <= 1'b0;
            // a bad phrase leaves the byte erased-looking
            option_r    <= opt_dbl_i ? `FCL_OPT_ERASED
                                     : opt_data_i;
            opt_state_r <= OPT_DONE;
          end
        end
        OPT_DONE: opt_rd_o <= 1'b0;
        default:  opt_state_r <= OPT_REQ;
      endcase
    end
  end

  // clock divider and time base; any write while idle marks it loaded
  // the tick is a one-cycle enable, not a second clock, so the whole
  // block stays in the bus clock domain
  // writes are held off while a command runs so that the program time
  // base cannot change under an active operation
  // the divide value is software's choice; nothing here checks that it
  // really gives the 1 MHz base
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      div_value_r     <= `FCL_DIV_RESET;
      div_loaded_r    <= 1'b0;
      tb_cnt_r        <= 7'h00;
      timebase_tick_o <= 1'b0;
    end else begin
      if (wr_clkdiv && command_complete_flag_r) begin
        div_value_r  <= reg_wdata_i[6:0];
        div_loaded_r <= 1'b1;
      end
      // tick every div_value+1 clocks, only once loaded
      if (!div_loaded_r || tb_cnt_r >= div_value_r) begin
        tb_cnt_r        <= 7'h00;
        timebase_tick_o <= div_loaded_r;
      end else begin
        tb_cnt_r        <= tb_cnt_r + 7'h01;
        timebase_tick_o <= 1'b0;
      end
    end
  end

  // index registers; object index locked while a command is active
  // the object index is frozen while busy so the engine's result
  // writes and the reader agree on which word is visible
  // the ecc index is free at all times: capture is independent of
  // the command engine
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      obj_idx_r <= 3'h0;
      ecc_idx_r <= 3'h0;
    end else begin
      if (wr_obj_idx && command_complete_flag_r)
        obj_idx_r <= reg_wdata_i[2:0];
      if (wr_ecc_idx)
        ecc_idx_r <= reg_wdata_i[2:0];
    end
  end

  // command object array: software writes when idle, engine returns
  // the two writers never overlap: software only while the complete
  // flag is one, the engine only while it is zero
  // indices 6 and 7 have no storage behind them, so their writes fall
  // away here and their reads are forced to zero in the read mux
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < 6; i = i + 1)
        obj_mem_r[i] <= 16'h0000;
    end else begin
      if (wr_obj && command_complete_flag_r && obj_idx_r < 3'd6)
        obj_mem_r[obj_idx_r] <= reg_wdata_i;
      if (cmd_res_we_i && !command_complete_flag_r && cmd_res_idx_i < 3'd6)
        obj_mem_r[cmd_res_idx_i] <= cmd_res_data_i;
    end
  end

  // status flags and command launch
  // the parameters are copied at launch, so later software writes
  // (which are refused anyway) could never reach a running command
  // a refused launch leaves the complete flag at one: software sees
  // the access error instead of a hung command
  // error clears in the launch cycle are ignored so that a refused
  // launch always leaves its error visible
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      command_complete_flag_r       <= 1'b1;
      access_error_flag_r     <= 1'b0;
      pviol_r      <= 1'b0;
      cmd_start_o  <= 1'b0;
      cmd_params_o <= 96'h0;
    end else begin
      cmd_start_o <= 1'b0;
      if (launch) begin
        if (is_pgm && !div_loaded_r) begin
          access_error_flag_r <= 1'b1;
        end else begin
          command_complete_flag_r       <= 1'b0;
          cmd_start_o  <= 1'b1;
          cmd_params_o <= {obj_mem_r[0], obj_mem_r[1], obj_mem_r[2],
                           obj_mem_r[3], obj_mem_r[4], obj_mem_r[5]};
        end
      end else begin
        // write-one clears; a same-cycle set wins
        if (wr_status && reg_wdata_i[`FCL_STAT_ACCESS_ERROR_FLAG_BIT])
          access_error_flag_r <= 1'b0;
        if (wr_status && reg_wdata_i[`FCL_STAT_PVIOL_BIT])
          pviol_r <= 1'b0;
      end
      if (!command_complete_flag_r && cmd_done_i) begin
        command_complete_flag_r <= 1'b1;
        if (cmd_pviol_i)
          pviol_r <= 1'b1;
      end
    end
  end

  // ecc capture: first fault latched until its flag is cleared
  // the gate looks at the flags as they stood before this edge, so a
  // fault arriving with the clearing write is not recorded; trade-off
  // for a capture that can never mix two faults in one record
  // both report pulses come from the read path on this same clock, so
  // no synchroniser is needed
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ecc_sgl_r  <= 1'b0;
      ecc_dbl_r  <= 1'b0;
      ecc_df_r   <= 1'b0;
      ecc_chk_r  <= 8'h00;
      ecc_addr_r <= 23'h00_0000;
      ecc_data_r <= 64'h0;
    end else begin
      if (wr_eflags && reg_wdata_i[`FCL_ECC_SINGLE_BIT])
        ecc_sgl_r <= 1'b0;
      if (wr_eflags && reg_wdata_i[`FCL_ECC_DOUBLE_BIT])
        ecc_dbl_r <= 1'b0;
      // new fault only while no flag stands; set beats clear
      if (ecc_any && !ecc_sgl_r && !ecc_dbl_r) begin
        if (ecc_double_i)
          ecc_dbl_r <= 1'b1;
        else
          ecc_sgl_r <= 1'b1;
        ecc_df_r   <= ecc_dflash_i;
        // data flash carries only six check bits
        ecc_chk_r  <= ecc_dflash_i ? {2'b00, ecc_check_i[5:0]}
                                   : ecc_check_i;
        ecc_addr_r <= ecc_addr_i;
        // data flash keeps its single word in word 0
        ecc_data_r <= ecc_dflash_i ? {ecc_data_i[15:0], 48'h0}
                                   : ecc_data_i;
      end
    end
  end

  // read mux; unmapped and reserved addresses read zero
  // purely combinational; the registered stage below makes the data
  // appear exactly one cycle after the strobe
  // no read has a side effect: flags clear only by explicit writes
  always @* begin
    rd_nxt = 16'h0000;
    case (reg_addr_i)
      `FCL_ADDR_CLKDIV:
        rd_nxt = {8'h00, div_loaded_r, div_value_r};
      `FCL_ADDR_OBJ_IDX: rd_nxt = {13'h0, obj_idx_r};
      `FCL_ADDR_ECC_IDX: rd_nxt = {13'h0, ecc_idx_r};
      `FCL_ADDR_STATUS:
        rd_nxt = {8'h00, command_complete_flag_r, 1'b0, access_error_flag_r, pviol_r, 4'h0};
      `FCL_ADDR_OBJ_DATA:
        if (obj_idx_r < 3'd6)
          rd_nxt = obj_mem_r[obj_idx_r];
        else
          rd_nxt = 16'h0000;
      `FCL_ADDR_ECC_DATA:
        case (ecc_idx_r)
          3'd0: rd_nxt = {ecc_chk_r, 1'b0, ecc_addr_r[22:16]};
          3'd1: rd_nxt = ecc_addr_r[15:0];
          3'd2, 3'd3, 3'd4, 3'd5:
            rd_nxt = phrase_word(ecc_data_r, ecc_idx_r[1:0] - 2'd2);
          default: rd_nxt = 16'h0000;
        endcase
      `FCL_ADDR_OPTION:  rd_nxt = {8'h00, option_r};
      `FCL_ADDR_ECC_FLAGS:
        rd_nxt = {13'h0, ecc_df_r, ecc_dbl_r, ecc_sgl_r};
      `FCL_ADDR_RSV0, `FCL_ADDR_RSV1, `FCL_ADDR_RSV2,
      `FCL_ADDR_RSV3, `FCL_ADDR_RSV4:
        rd_nxt = 16'h0000;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // registered read data, valid only the cycle after the strobe
  // returning zero when idle keeps stale register contents off the
  // bus and makes a missed strobe easy to spot
  always @(posedge core_clk_i) begin
    if (!reset_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_nxt;
    else
      reg_rdata_o <= 16'h0000;
  end

endmodule // fcl_top

// [fcl_top_bench.sv]
`timescale 1ns/1ps
module fcl_top_bench;
  reg         core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, opt_valid_i;
  reg         opt_dbl_i, ecc_single_i, ecc_double_i, ecc_dflash_i;
  reg         cmd_done_i, cmd_pviol_i, cmd_res_we_i;
  reg  [4:0]  reg_addr_i;
  reg  [15:0] reg_wdata_i, cmd_res_data_i;
  reg  [7:0]  opt_data_i, ecc_check_i;
  reg  [22:0] ecc_addr_i;
  reg  [63:0] ecc_data_i;
  reg  [2:0]  cmd_res_idx_i;
  wire [15:0] reg_rdata_o;
  wire        opt_rd_o, cmd_start_o, timebase_tick_o;
  wire [22:0] opt_addr_o;
  wire [95:0] cmd_params_o;
  integer     bad_count, n_checks, k, ticks;
  reg  [95:0] exp_p;  // command words, word 0 on top
  reg  [127:0] exp_w; // capture window, index 0 on top
  fcl_top i_fcl_top (.*);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task results;
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input [95:0] e, input [95:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [4:0] a, input [15:0] m, input [15:0] e, input string nm);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, e, reg_rdata_o & m);
  endtask
  task ecc(input s, d, f, input [7:0] c, input [22:0] a, input [63:0] x);
    @(posedge core_clk_i);
    {ecc_single_i, ecc_double_i, ecc_dflash_i} <= {s, d, f};
    {ecc_check_i, ecc_addr_i, ecc_data_i} <= {c, a, x};
    @(posedge core_clk_i);
    {ecc_single_i, ecc_double_i} <= 2'b00;
  endtask
  // reset, then answer the option fetch; bounded wait for the request
  task boot(input dbl);
    reset_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    k = 0;
    while (opt_rd_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1 k = k + 1;
      if (k > 20) begin
        bad_count = bad_count + 1;
        results;
      end
    end
    @(posedge core_clk_i);
    {opt_valid_i, opt_dbl_i, opt_data_i} <= {1'b1, dbl, 8'h5a};
    @(posedge core_clk_i);
    opt_valid_i <= 1'b0;
  endtask
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, opt_valid_i, opt_dbl_i} = 5'h00;
    {ecc_single_i, ecc_double_i, ecc_dflash_i, cmd_done_i} = 4'h0;
    {cmd_pviol_i, cmd_res_we_i, reg_addr_i, reg_wdata_i} = 23'h00_0000;
    {cmd_res_data_i, opt_data_i, ecc_check_i, cmd_res_idx_i} = 35'h0;
    {ecc_addr_i, ecc_data_i} = 87'h0;
    bad_count = 0;
    n_checks = 0;
    boot(1'b0);
    rd(5'h06, 16'hffff, 16'h005a, "option");
    wr(5'h06, 16'hffff);
    rd(5'h06, 16'hffff, 16'h005a, "option ro");
    for (k = 8; k < 13; k = k + 1) begin
      wr(k[4:0], 16'hffff);
      rd(k[4:0], 16'hffff, 16'h0000, "reserved");
    end
    rd(5'h1f, 16'hffff, 16'h0000, "unmapped");
    rd(5'h00, 16'hffff, 16'h0000, "divider");
    // program code with no divider: refused, access error
    wr(5'h01, 16'h0000);
    wr(5'h04, 16'h0600);
    wr(5'h03, 16'h0080);
    #1 chk("start", 1'b0, cmd_start_o);
    rd(5'h03, 16'h00b0, 16'h00a0, "status");
    wr(5'h03, 16'h0020);
    rd(5'h03, 16'h00b0, 16'h0080, "status");
    wr(5'h00, 16'h0005);
    rd(5'h00, 16'h00ff, 16'h0085, "divider");
    // divide value 5 gives one tick every 6 clocks
    ticks = 0;
    repeat (60) begin
      @(posedge core_clk_i);
      #1;
      if (timebase_tick_o === 1'b1)
        ticks = ticks + 1;
    end
    chk("tick count", 10, ticks);
    exp_p = {16'h0600, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    for (k = 0; k < 6; k = k + 1) begin
      wr(5'h01, k[15:0]);
      wr(5'h04, exp_p[95-16*k -: 16]);
    end
    wr(5'h01, 16'h0006);
    wr(5'h04, 16'hbeef);
    rd(5'h04, 16'hffff, 16'h0000, "obj idx6");
    wr(5'h01, 16'h0002);
    rd(5'h04, 16'hffff, 16'h2222, "obj word");
    wr(5'h03, 16'h0080);
    #1 chk("start", 1'b1, cmd_start_o);
    chk("params", exp_p, cmd_params_o);
    rd(5'h03, 16'h0080, 16'h0000, "busy flag");
    // writes while busy must be dropped, relaunch too
    wr(5'h04, 16'h1234);
    wr(5'h03, 16'h0080);
    @(posedge core_clk_i);
    {cmd_res_we_i, cmd_res_idx_i, cmd_res_data_i} <= {1'b1, 3'h1, 16'hcafe};
    @(posedge core_clk_i);
    cmd_res_we_i <= 1'b0;
    cmd_done_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_done_i <= 1'b0;
    rd(5'h03, 16'h0080, 16'h0080, "done flag");
    rd(5'h04, 16'hffff, 16'h2222, "locked word");
    wr(5'h01, 16'h0001);
    rd(5'h04, 16'hffff, 16'hcafe, "result");
    // simultaneous faults, then a later one that must not overwrite
    ecc(1'b1, 1'b1, 1'b0, 8'ha5, 23'h12_3456, 64'h1111_2222_3333_4444);
    rd(5'h07, 16'h0002, 16'h0002, "dbl flag");
    ecc(1'b1, 1'b0, 1'b0, 8'h11, 23'h00_0001, 64'h0);
    exp_w = {16'ha512, 16'h3456, 64'h1111_2222_3333_4444, 32'h0};
    for (k = 0; k < 8; k = k + 1) begin
      wr(5'h02, k[15:0]);
      rd(5'h05, 16'hffff, exp_w[127-16*k -: 16], "ecc win");
    end
    wr(5'h07, 16'h0003);
    ecc(1'b1, 1'b0, 1'b1, 8'hff, 23'h10_0010, 64'h0abc);
    wr(5'h02, 16'h0000);
    rd(5'h05, 16'hffff, 16'h3f10, "dflash chk");
    wr(5'h02, 16'h0002);
    rd(5'h05, 16'hffff, 16'h0abc, "dflash data");
    boot(1'b1);
    rd(5'h06, 16'hffff, 16'h00ff, "option dbl");
    rd(5'h00, 16'hffff, 16'h0000, "divider");
    results;
  end
endmodule // fcl_top_bench

// [fcl_top_properties.sv]
`timescale 1ns/1ps
// watches the register port, option fetch and command launch
module fcl_top_props (
  input wire        core_clk_i,
  input wire        reset_n_i,
  input wire [4:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire        opt_rd_o,
  input wire [22:0] opt_addr_o,
  input wire        opt_valid_i,
  input wire [7:0]  opt_data_i,
  input wire        opt_dbl_i,
  input wire        cmd_start_o,
  input wire        cmd_done_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  reg       busy_r; // engine owns the launch
  reg [8:0] opt_r;  // {loaded, expected option byte}
  // shadow of the engine state and of the fetched option byte
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      busy_r <= 1'b0;
      opt_r  <= 9'h000;
    end else begin
      if (cmd_start_o)
        busy_r <= 1'b1;
      else if (cmd_done_i)
        busy_r <= 1'b0;
      // a double fault forces the erased value
      if (opt_rd_o && opt_valid_i)
        opt_r <= {1'b1, opt_dbl_i ? 8'hff : opt_data_i};
    end
  end
  chk_rsv_read_zero: assert property (
    reg_rd_i && reg_addr_i >= 5'h08 && reg_addr_i <= 5'h0c
    |=> reg_rdata_o == 16'h0000) else $error("reserved read not zero");
  chk_opt_fetch_addr: assert property (
    opt_rd_o |-> opt_addr_o == 23'h7f_ff0e) else $error("option address");
  chk_opt_req_hold: assert property (
    opt_rd_o && !opt_valid_i |=> opt_rd_o) else $error("option req dropped");
  chk_opt_req_end: assert property (
    opt_rd_o && opt_valid_i |=> !opt_rd_o) else $error("option req stuck");
  chk_opt_read_value: assert property (
    reg_rd_i && reg_addr_i == 5'h06 && opt_r[8]
    |=> reg_rdata_o == {8'h00, opt_r[7:0]}) else $error("option value");
  chk_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("rdata not idle");
  chk_launch_cause: assert property (
    cmd_start_o |-> $past(reg_wr_i && reg_addr_i == 5'h03 && reg_wdata_i[7]))
    else $error("start without launch write");
  chk_busy_no_start: assert property (
    busy_r |-> !cmd_start_o) else $error("start while busy");
  cover property (cmd_start_o);
  cover property (busy_r && cmd_done_i);
  cover property (opt_rd_o && opt_valid_i && opt_dbl_i);
endmodule // fcl_top_props

bind fcl_top fcl_top_props i_fcl_top_props (.*);
